/* rtl/qic_top.sv */
`timescale 1ns/100ps
module qic_top #(
    parameter int NUM_CH = 4
) (
    input logic clock_i,
    input logic nrst_i,
    input logic [qic_pkg::ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [qic_pkg::ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [NUM_CH-1:0] enc_a_i,
    input logic [NUM_CH-1:0] enc_b_i,
    input logic [NUM_CH-1:0] enc_idx_i
);
    localparam int AW = qic_pkg::ADDR_W;
    localparam int CW = qic_pkg::CNT_W;

    qic_pkg::qic_cfg_t cfg_ff [NUM_CH];
    qic_pkg::qic_cfg_t nxt_cfg [NUM_CH];
    qic_pkg::qic_sts_t sts [NUM_CH];
    logic [NUM_CH-1:0] restart_ff, nxt_restart;
    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [AW-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata, wword;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic aw_hs, w_hs, ar_hs;
    logic [1:0] wr_ch, rd_ch;

    // ======================================================
    // register helpers
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[8*i+:8] = s[i] ? d[8*i+:8] : old[8*i+:8];
        end
    endfunction

    function automatic logic [31:0] ctrl_word(input qic_pkg::qic_cfg_t c);
        ctrl_word = '0;
        ctrl_word[qic_pkg::CTRL_IDX_EN] = c.idx_en;
        ctrl_word[qic_pkg::CTRL_IDX_RISE] = c.idx_rise;
        ctrl_word[qic_pkg::CTRL_MODE_LSB+:2] = c.mode;
        ctrl_word[qic_pkg::CTRL_RES_LSB+:2] = c.res;
        ctrl_word[qic_pkg::CTRL_PSC_LSB+:8] = c.psc;
    endfunction

    function automatic logic reg_ok(input logic [AW-1:0] a,
                                    input logic wr);
        reg_ok = (a[AW-1:qic_pkg::CH_LSB+2] == '0) &&
                 (int'(a[qic_pkg::CH_LSB+:2]) < NUM_CH) &&
                 (a[3:0] == qic_pkg::REG_CTRL ||
                  a[3:0] == qic_pkg::REG_PRESET ||
                  (!wr && a[3:0] == qic_pkg::REG_COUNT));
    endfunction

    // handshakes; one write and one read in flight
    assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign wr_ch = awaddr_ff[qic_pkg::CH_LSB+:2];
    assign rd_ch = s_axi_araddr[qic_pkg::CH_LSB+:2];

    // ======================================================
    // write channel and configuration registers
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_got = w_got_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_cfg = cfg_ff;
        nxt_restart = '0;
        wword = '0;
        if (aw_hs) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (aw_got_ff && w_got_ff) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = qic_pkg::RESP_SLVERR;
            if (reg_ok(awaddr_ff, 1'b1)) begin
                nxt_bresp = qic_pkg::RESP_OKAY;
                if (awaddr_ff[3:0] == qic_pkg::REG_CTRL) begin
                    wword = merge(ctrl_word(cfg_ff[wr_ch]), wdata_ff,
                                  wstrb_ff);
                    nxt_cfg[wr_ch].idx_en =
                        wword[qic_pkg::CTRL_IDX_EN];
                    nxt_cfg[wr_ch].idx_rise =
                        wword[qic_pkg::CTRL_IDX_RISE];
                    nxt_cfg[wr_ch].mode = qic_pkg::qic_mode_t'(
                        wword[qic_pkg::CTRL_MODE_LSB+:2]);
                    nxt_cfg[wr_ch].res = qic_pkg::qic_res_t'(
                        wword[qic_pkg::CTRL_RES_LSB+:2]);
                    nxt_cfg[wr_ch].psc =
                        wword[qic_pkg::CTRL_PSC_LSB+:8];
                    nxt_restart[wr_ch] = 1'b1; // start of a run
                end else begin
                    wword = merge({{(32-CW){1'b0}},
                                   cfg_ff[wr_ch].preset_limit_value},
                                  wdata_ff, wstrb_ff);
                    nxt_cfg[wr_ch].preset_limit_value =
                        wword[CW-1:0];
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= '0;
            w_got_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= qic_pkg::RESP_OKAY;
            restart_ff <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_ff[i] <= qic_pkg::CFG_RST;
            end
        end else begin
            aw_got_ff <= nxt_aw_got;
            awaddr_ff <= nxt_awaddr;
            w_got_ff <= nxt_w_got;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            restart_ff <= nxt_restart;
            cfg_ff <= nxt_cfg;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ======================================================
    // read channel
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (ar_hs) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = 32'h0000_0000;
            nxt_rresp = qic_pkg::RESP_SLVERR;
            if (reg_ok(s_axi_araddr, 1'b0)) begin
                nxt_rresp = qic_pkg::RESP_OKAY;
                case (s_axi_araddr[3:0])
                    qic_pkg::REG_CTRL: nxt_rdata = ctrl_word(cfg_ff[rd_ch]);
                    qic_pkg::REG_PRESET:
                        nxt_rdata = {{(32-CW){1'b0}},
                                     cfg_ff[rd_ch].preset_limit_value};
                    default:
                        nxt_rdata = {{(32-CW){1'b0}},
                                     sts[rd_ch].count};
                endcase
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= qic_pkg::RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ======================================================
    // counting channels, one filter and counter each
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        qic_pkg::qic_enc_t filt;
        qic_filter u_filt (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .psc_i(cfg_ff[g].psc),
            .enc_i('{a: enc_a_i[g], b: enc_b_i[g], idx: enc_idx_i[g]}),
            .enc_o(filt)
        );
        qic_channel u_chan (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .restart_i(restart_ff[g]),
            .cfg_i(cfg_ff[g]),
            .enc_i(filt),
            .sts_o(sts[g])
        );
    end

    // ======================================================
    // checks on channel 0 and the bus
    logic [CW-1:0] c0_cnt, c0_lim;
    logic c0_up, c0_dn, c0_idx, c0_rst;
    qic_pkg::qic_mode_t c0_mode;
    assign c0_cnt = sts[0].count;
    assign c0_up = sts[0].up;
    assign c0_dn = sts[0].dn;
    assign c0_idx = sts[0].idx_evt;
    assign c0_rst = restart_ff[0];
    assign c0_lim = cfg_ff[0].preset_limit_value;
    assign c0_mode = cfg_ff[0].mode;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_up;
        c0_up && !c0_idx && !c0_rst;
    endsequence
    sequence s_dn;
        c0_dn && !c0_idx && !c0_rst;
    endsequence
    sequence s_rd_cnt0;
        ar_hs && s_axi_araddr == AW'(qic_pkg::REG_COUNT);
    endsequence

    property p_cnt_read;
        s_rd_cnt0 |=> s_axi_rvalid &&
            s_axi_rdata == {{(32-CW){1'b0}}, $past(c0_cnt)};
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("read");

    property p_up_step;
        s_up and (c0_mode == qic_pkg::MODE_FREE) |=>
            c0_cnt == $past(c0_cnt) + 1'b1;
    endproperty
    a_up_step: assert property (p_up_step) else $error("up step");

    property p_idx_load;
        c0_idx && !c0_rst |=> c0_cnt == $past(c0_lim);
    endproperty
    a_idx_load: assert property (p_idx_load) else $error("index");

    property p_restart;
        c0_rst |=> c0_cnt == ($past(cfg_ff[0].idx_en) ? $past(c0_lim) : '0);
    endproperty
    a_restart: assert property (p_restart) else $error("start value");

    property p_free_wrap;
        s_up and (c0_mode == qic_pkg::MODE_FREE && c0_cnt == '1) |=>
            c0_cnt == '0;
    endproperty
    a_free_wrap: assert property (p_free_wrap) else $error("wrap");

    property p_range_top;
        s_up and (c0_mode == qic_pkg::MODE_RANGE && c0_cnt == c0_lim) |=>
            c0_cnt == $past(c0_lim);
    endproperty
    a_range_top: assert property (p_range_top) else $error("limit");

    property p_nonrec_floor;
        s_dn and (c0_mode == qic_pkg::MODE_NONREC && c0_cnt == '0) |=>
            c0_cnt == '0;
    endproperty
    a_nonrec_floor: assert property (p_nonrec_floor)
        else $error("floor");

    property p_mod_wrap;
        s_dn and (c0_mode == qic_pkg::MODE_MODN && c0_cnt == '0) |=>
            c0_cnt == $past(c0_lim) ##1 1'b1;
    endproperty
    a_mod_wrap: assert property (p_mod_wrap) else $error("modulo");

    // count only moves on a decoded step, index or restart
    property p_one_step;
        !c0_up && !c0_dn && !c0_idx && !c0_rst |=>
            c0_cnt == $past(c0_cnt);
    endproperty
    a_one_step: assert property (p_one_step) else $error("moved");

    property p_wr_resp;
        aw_hs && w_hs |-> ##2 s_axi_bvalid [*1];
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response");
endmodule // qic_top

/* pkg/qic_pkg.sv */
package qic_pkg;
    // ======================================================
    // sizes and register map
    localparam int CNT_W = 24;
    localparam int ADDR_W = 8;
    localparam int CH_LSB = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PRESET = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;
    // ======================================================
    // control word field positions, preset reset value and response codes
    localparam int CTRL_IDX_EN = 0;
    localparam int CTRL_IDX_RISE = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_RES_LSB = 4;
    localparam int CTRL_PSC_LSB = 8;
    localparam logic [CNT_W-1:0] PRESET_RST = 24'h00_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ======================================================
    // modes and carriers
    typedef enum logic [1:0] {
        MODE_FREE, MODE_RANGE, MODE_NONREC, MODE_MODN
    } qic_mode_t;
    typedef enum logic [1:0] {RES_NONQ, RES_X1, RES_X2, RES_X4} qic_res_t;
    typedef struct packed {
        logic idx_en;
        logic idx_rise;
        qic_mode_t mode;
        qic_res_t res;
        logic [7:0] psc;
        logic [CNT_W-1:0] preset_limit_value;
    } qic_cfg_t;
    typedef struct packed {
        logic a;
        logic b;
        logic idx;
    } qic_enc_t;
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic up;
        logic dn;
        logic idx_evt;
    } qic_sts_t;
    localparam qic_cfg_t CFG_RST = '{idx_en: 1'b0, idx_rise: 1'b1,
        mode: MODE_FREE, res: RES_X4, psc: 8'h00,
        preset_limit_value: PRESET_RST};
endpackage

/* rtl/qic_filter.sv */
`timescale 1ns/100ps
module qic_filter (
    input logic clock_i,
    input logic nrst_i,
    input logic [7:0] psc_i,
    input qic_pkg::qic_enc_t enc_i,
    output qic_pkg::qic_enc_t enc_o
);
    logic [2:0] s1_ff, s2_ff, s3_ff, stab_ff, last_ff, out_ff;
    logic [2:0] nxt_stab, nxt_last, nxt_out, agree, same;
    logic [7:0] psc_ff, nxt_psc;

    // ======================================================
    // debounce of the pins, then prescaled two-sample filter
    always_comb begin
        agree = ~(s2_ff ^ s3_ff);
        nxt_stab = (agree & s3_ff) | (~agree & stab_ff);
        same = ~(stab_ff ^ last_ff);
        nxt_psc = psc_ff + 8'h01;
        nxt_last = last_ff;
        nxt_out = out_ff;
        if (psc_ff >= psc_i) begin
            nxt_psc = 8'h00;
            nxt_last = stab_ff;
            nxt_out = (same & stab_ff) | (~same & out_ff);
        end
    end

    // registers; s1 feeds only s2
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_ff <= 3'h0;
            s2_ff <= 3'h0;
            s3_ff <= 3'h0;
            stab_ff <= 3'h0;
            last_ff <= 3'h0;
            out_ff <= 3'h0;
            psc_ff <= 8'h00;
        end else begin
            s1_ff <= enc_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            stab_ff <= nxt_stab;
            last_ff <= nxt_last;
            out_ff <= nxt_out;
            psc_ff <= nxt_psc;
        end
    end

    assign enc_o = qic_pkg::qic_enc_t'(out_ff);
endmodule // qic_filter

/* rtl/qic_channel.sv */
`timescale 1ns/100ps
module qic_channel (
    input logic clock_i,
    input logic nrst_i,
    input logic restart_i,
    input qic_pkg::qic_cfg_t cfg_i,
    input qic_pkg::qic_enc_t enc_i,
    output qic_pkg::qic_sts_t sts_o
);
    logic [qic_pkg::CNT_W-1:0] count_ff, nxt_count, lim;
    qic_pkg::qic_enc_t prev_ff;
    logic sat_ff, nxt_sat, up, dn, idx_evt, chg_a, chg_b, cw, idx_edge;

    // ======================================================
    // quadrature step and index edge decode
    always_comb begin
        chg_a = enc_i.a ^ prev_ff.a;
        chg_b = enc_i.b ^ prev_ff.b;
        cw = ~(prev_ff.a ^ enc_i.b);
        up = 1'b0;
        dn = 1'b0;
        case (cfg_i.res)
            qic_pkg::RES_NONQ: up = enc_i.a & ~prev_ff.a;
            qic_pkg::RES_X1: begin
                up = ({prev_ff.a, prev_ff.b} == 2'h0) &&
                     ({enc_i.a, enc_i.b} == 2'h2);
                dn = ({prev_ff.a, prev_ff.b} == 2'h2) &&
                     ({enc_i.a, enc_i.b} == 2'h0);
            end
            qic_pkg::RES_X2: begin
                up = chg_a & ~chg_b & cw;
                dn = chg_a & ~chg_b & ~cw;
            end
            default: begin
                up = (chg_a ^ chg_b) & cw;
                dn = (chg_a ^ chg_b) & ~cw;
            end
        endcase
        idx_edge = cfg_i.idx_rise ? (enc_i.idx & ~prev_ff.idx)
                                  : (~enc_i.idx & prev_ff.idx);
        idx_evt = cfg_i.idx_en & idx_edge &
                  ~(cfg_i.mode == qic_pkg::MODE_NONREC && sat_ff);
    end

    // ======================================================
    // count update per mode
    always_comb begin
        lim = cfg_i.preset_limit_value;
        nxt_count = count_ff;
        nxt_sat = sat_ff;
        if (restart_i) begin
            nxt_count = cfg_i.idx_en ? lim : '0;
            nxt_sat = 1'b0;
        end else if (idx_evt) begin
            nxt_count = lim;
        end else if (up) begin
            case (cfg_i.mode)
                qic_pkg::MODE_RANGE:
                    nxt_count = (count_ff == lim) ? lim
                                : count_ff + 1'b1;
                qic_pkg::MODE_MODN:
                    nxt_count = (count_ff == lim) ? '0
                                : count_ff + 1'b1;
                default: nxt_count = count_ff + 1'b1;
            endcase
        end else if (dn) begin
            case (cfg_i.mode)
                qic_pkg::MODE_RANGE:
                    nxt_count = (!cfg_i.idx_en && count_ff == '0) ? '0
                                : count_ff - 1'b1;
                qic_pkg::MODE_NONREC: begin
                    nxt_count = (count_ff == '0) ? '0
                                : count_ff - 1'b1;
                    nxt_sat = sat_ff | (count_ff <= 24'h00_0001);
                end
                qic_pkg::MODE_MODN:
                    nxt_count = (count_ff == '0) ? lim
                                : count_ff - 1'b1;
                default: nxt_count = count_ff - 1'b1;
            endcase
        end
    end

    // registers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_ff <= qic_pkg::PRESET_RST;
            sat_ff <= 1'b0;
            prev_ff <= '0;
        end else begin
            count_ff <= nxt_count;
            sat_ff <= nxt_sat;
            prev_ff <= enc_i;
        end
    end

    assign sts_o = '{count: count_ff, up: up, dn: dn, idx_evt: idx_evt};
endmodule // qic_channel

/* verif/qic_enc_model.sv */
`timescale 1ns/100ps
// ======================================
// quadrature encoder, one phase per channel
module qic_enc_model #(
    parameter int NUM_CH = 4,
    parameter int HOLD = 16
) (
    input wire logic clock_i,
    output logic [NUM_CH-1:0] a_o,
    output logic [NUM_CH-1:0] b_o,
    output logic [NUM_CH-1:0] idx_o
);
    logic [1:0] ph [NUM_CH];
    // idle levels at time zero
    initial begin
        a_o = '0;
        b_o = '0;
        idx_o = '0;
        foreach (ph[i]) ph[i] = 2'h0;
    end
    // one step; cw gives AB 00 10 11 01, so A leads B
    task automatic step(input int ch, input bit cw);
        ph[ch] = cw ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
        @(posedge clock_i);
        a_o[ch] <= ph[ch][1] ^ ph[ch][0];
        b_o[ch] <= ph[ch][1];
        repeat (HOLD) @(posedge clock_i);
    endtask
    // index level change, held long enough to pass the filter
    task automatic index(input int ch, input bit lvl);
        @(posedge clock_i);
        idx_o[ch] <= lvl;
        repeat (HOLD) @(posedge clock_i);
    endtask
    // short noise pulse on A
    task automatic glitch(input int ch);
        @(posedge clock_i);
        a_o[ch] <= ~a_o[ch];
        repeat (2) @(posedge clock_i);
        a_o[ch] <= ~a_o[ch];
        repeat (HOLD) @(posedge clock_i);
    endtask
endmodule // qic_enc_model

/* verif/qic_top_tb.sv */
`timescale 1ns/100ps
module qic_top_tb;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] awaddr = '0;
    logic [7:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] enc_a, enc_b, enc_idx;
    logic [33:0] rq [$];
    logic [1:0] wq [$];
    logic [23:0] rp;
    int errors = 0;
    int check_count = 0;
    int res_exp [4] = '{1, 1, 2, 4};
    // ======================================
    // clock, design and encoder
    always #2 clock_i = ~clock_i;
    qic_top #(.NUM_CH(4)) u_dut (
        .clock_i(clock_i), .nrst_i(nrst_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .enc_a_i(enc_a),
        .enc_b_i(enc_b), .enc_idx_i(enc_idx)
    );
    qic_enc_model #(.NUM_CH(4), .HOLD(16)) u_enc (
        .clock_i(clock_i), .a_o(enc_a), .b_o(enc_b), .idx_o(enc_idx)
    );
    // ======================================
    // compare tasks and result monitor
    task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t rd got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_wr(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t wr got %h exp %h", $time, got, exp);
        end
    endtask
    always @(posedge clock_i) begin
        if (rvalid === 1'b1 && rready) chk_rd({rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1 && bready) chk_wr(bresp, wq.pop_front());
    end
    // ======================================
    // bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        bit aw, w, b;
        aw = 0;
        w = 0;
        b = 0;
        wq.push_back(r);
        @(posedge clock_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(posedge clock_i);
            if (aw && w && bvalid === 1'b1) begin
                b = 1;
                bready <= 1'b0;
            end
            if (!aw && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        bit ar, b;
        ar = 0;
        b = 0;
        rq.push_back({r, d});
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!b) begin
            @(posedge clock_i);
            if (ar && rvalid === 1'b1) begin
                b = 1;
                rready <= 1'b0;
            end
            if (!ar && arready === 1'b1) begin
                ar = 1;
                arvalid <= 1'b0;
            end
        end
    endtask
    function automatic logic [7:0] ad(input int ch, input logic [3:0] off);
        return {ch[3:0], off};
    endfunction
    // preset then control; the control write restarts the channel
    task automatic setup(input int ch, input logic [23:0] p, input int c);
        wr(ad(ch, qic_pkg::REG_PRESET), {8'h00, p}, qic_pkg::RESP_OKAY);
        wr(ad(ch, qic_pkg::REG_CTRL), 32'(c), qic_pkg::RESP_OKAY);
    endtask
    task automatic cnt(input int ch, input logic [23:0] e);
        repeat (40) @(posedge clock_i);
        rd(ad(ch, qic_pkg::REG_COUNT), {8'h00, e}, qic_pkg::RESP_OKAY);
    endtask
    task automatic steps(input int ch, input bit cw, input int n);
        repeat (n) u_enc.step(ch, cw);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ======================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        $display("watchdog expired");
        results();
    end
    // ======================================
    // tests
    initial begin
        void'($urandom(32'h3b415695));
        repeat (8) @(posedge clock_i);
        nrst_i <= 1'b1;
        for (int ch = 0; ch < 4; ch++) begin
            rd(ad(ch, qic_pkg::REG_CTRL), 32'h32, qic_pkg::RESP_OKAY);
            rd(ad(ch, qic_pkg::REG_PRESET), 0, qic_pkg::RESP_OKAY);
            rd(ad(ch, qic_pkg::REG_COUNT), 0, qic_pkg::RESP_OKAY);
        end
        rd(8'h0c, 0, qic_pkg::RESP_SLVERR);
        wr(ad(0, qic_pkg::REG_COUNT), 1, qic_pkg::RESP_SLVERR);
        $display("test reset done");
        setup(0, 24'h0, 32'h30);
        steps(0, 0, 3);
        cnt(0, 24'hfffffd);
        steps(0, 1, 5);
        cnt(0, 24'h000002);
        setup(1, 24'h3, 32'h34);
        steps(1, 1, 5);
        cnt(1, 24'h3);
        steps(1, 0, 5);
        cnt(1, 24'h0);
        setup(2, 24'h2, 32'h3c);
        steps(2, 1, 4);
        cnt(2, 24'h1);
        steps(2, 0, 2);
        cnt(2, 24'h2);
        $display("test modes done");
        rp = 24'($urandom);
        wr(ad(3, qic_pkg::REG_PRESET), {8'($urandom), rp}, 2'h0);
        rd(ad(3, qic_pkg::REG_PRESET), {8'h00, rp}, 2'h0);
        wstrb <= 4'h1; // low byte lane only
        wr(ad(3, qic_pkg::REG_PRESET), 32'hffff_ffa5, 2'h0);
        rp[7:0] = 8'ha5;
        wstrb <= 4'hf;
        rd(ad(3, qic_pkg::REG_PRESET), {8'h00, rp}, 2'h0);
        wr(ad(3, qic_pkg::REG_CTRL), 32'h33, qic_pkg::RESP_OKAY);
        cnt(3, rp);
        steps(3, 1, 2);
        cnt(3, rp + 24'h2);
        u_enc.index(3, 1);
        cnt(3, rp);
        u_enc.index(3, 0);
        wr(ad(3, qic_pkg::REG_CTRL), 32'h31, qic_pkg::RESP_OKAY);
        steps(3, 1, 1);
        u_enc.index(3, 1);
        cnt(3, rp + 24'h1);
        u_enc.index(3, 0);
        cnt(3, rp);
        $display("test index done");
        setup(0, 24'h2, 32'h3b);
        cnt(0, 24'h2);
        steps(0, 0, 1);
        u_enc.index(0, 1);
        cnt(0, 24'h2);
        u_enc.index(0, 0);
        steps(0, 0, 4);
        cnt(0, 24'h0);
        u_enc.index(0, 1);
        u_enc.index(0, 0);
        cnt(0, 24'h0);
        setup(1, 24'h2, 32'h37);
        steps(1, 1, 4);
        cnt(1, 24'h2);
        cnt(2, 24'h2);
        // modulo and range on channel 0, where the checks watch
        setup(0, 24'h2, 32'h3c);
        steps(0, 0, 1);
        cnt(0, 24'h2);
        setup(0, 24'h2, 32'h37);
        steps(0, 1, 1);
        cnt(0, 24'h2);
        $display("test limits done");
        for (int r = 0; r < 4; r++) begin
            setup(2, 24'h0, r * 16);
            steps(2, 1, 4);
            cnt(2, 24'(res_exp[r]));
        end
        setup(0, 24'h0, 32'h0430);
        u_enc.glitch(0);
        cnt(0, 24'h0);
        steps(0, 1, 1);
        cnt(0, 24'h1);
        $display("test resolution and filter done");
        results();
    end
endmodule // qic_top_tb
